//--- spa_autoload_pkg.sv
// Shared constants and carrier types for the serial PROM autoloader.
// Assumes a 200 MHz system clock and an external sample-rate clock pin.
package spa_autoload_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and pulse timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CFG_HALF_NS   = 160;
    // Least time, rounded up to whole cycles, never below one
    localparam int CFG_HALF_CYC_I = (CFG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] CFG_HALF_CYC = 6'(CFG_HALF_CYC_I > 0 ? CFG_HALF_CYC_I : 1);
    // Cycle inside the high phase where the synchronised data bit is taken
    localparam logic [5:0] SAMPLE_AT = 6'h02;

    ////////////////////////////////////////////////////////////////////////////
    // Sequence lengths
    localparam logic [10:0] PLL_WAIT_PERIODS = 11'h400;
    localparam logic [10:0] MUTE_PERIODS     = 11'h400;
    localparam logic [9:0]  LAST_WORD_ADDR   = 10'h3ff;
    localparam logic [5:0]  WORD_BITS        = 6'h28;
    localparam logic [5:0]  CFG_BITS         = 6'h10;
    localparam logic [5:0]  CFG_BYTE_BITS    = 6'h08;
    localparam logic [1:0]  STRAP_SETTLE     = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration byte 0 field positions
    localparam int CFG0_OUT_EN_LSB = 3;
    localparam int CFG0_OUT_EN_MSB = 6;
    localparam int CFG0_IN_EN_BIT  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic        we;
        logic [9:0]  addr;
        logic [39:0] data;
    } spa_imem_wr_t;

    typedef struct packed {
        logic [3:0] outEnable;
        logic       inEnable;
    } spa_audio_en_t;

    typedef enum logic [2:0] {
        ST_STRAP, ST_PLL_WAIT, ST_WAIT_EDGE, ST_CLK_HIGH,
        ST_CLK_LOW, ST_MUTED, ST_RUN, ST_OFF
    } spa_state_t;

endpackage

//--- spa_sync_rise.sv
// Two-flop synchroniser with rising-edge detector for one pin input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module spa_sync_rise #(
    parameter logic RST_LEVEL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise
);

    ////////////////////////////////////////////////////////////////////////////
    logic stage1;
    logic stage2;
    logic stage3;

    // Stage 1 feeds only stage 2; stage 3 remembers the old level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RST_LEVEL;
            stage2 <= RST_LEVEL;
            stage3 <= RST_LEVEL;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Level and one-cycle rising pulse
    assign level = stage2;
    assign rise  = stage2 & ~stage3;

endmodule // spa_sync_rise

//--- spa_autoloader.sv
// Boot sequencer that loads instruction memory and two config bytes from
// an external serial PROM, then releases audio I/O after a muted run.
// Assumes the PROM presents each bit before the rising clock edge we drive.
// Assumes clk runs far faster than the sample-rate clock pin.
// Assumes the straps are stable from reset release onward.
//
// Behaviour
// RL1: Autoload only when select low, host-select high.
// RL2: Drive clock on pin 1, read pin 0.
// RL3: PROM holds 1024 words plus two bytes.
// RL4: MSB first, 40 bits per word, ascending.
// RL5: Then config byte 0, then byte 1.
// RL6: Bits past the image are never clocked.
// RL7: Pins held, supplies settle, then reset released.
// RL8: Wait 1024 sample periods before any pulse.
// RL9: Forty 160ns-high, 160ns-low pulses per period.
// RL10: Take one bit per rising clock edge.
// RL11: One word per group, then sixteen config pulses.
// RL12: Muted for 1024 periods, then enable per config.
// RL13: Byte 0 bits 6:3 outputs, bit 2 inputs.
// RL14: Write word after bit forty; byte after eight.
// RL15: Reset aborts and restarts from the PLL wait.
//
// Sequence
// Straps are judged a few cycles after reset release.
// Autoload mode counts sample-clock rises as the PLL wait.
// The last wait rise, then each later rise outside a group, opens one group of pulses.
// Groups 0 to 1023 fill one instruction word each.
// The next group has sixteen pulses for both config bytes.
// The clock pin then stays low; no more bits are read.
// A muted run of sample periods follows, then enables apply.
//
// Hazards
// Data is read two cycles into the high phase, after the
// synchroniser, so the PROM must hold each bit to the first clk edge after the rise.
// Sample rises inside a group are ignored; a sample period
// shorter than a group stretches the load to one word per
// rise that lands outside a group.
// Straps are not watched again once the mode is chosen.
// The write strobe lasts one cycle; address and data hold
// until the next word is written.
// The clock pin readback input is not used.
`timescale 1ns/1ps
module spa_autoloader (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          autoloadSelectN,
    input  wire logic                          serialHostSelectN,
    input  wire logic                          sampleRateClock,
    input  wire logic                          cfgClockLineIn,
    output logic                               cfgClockLineOut,
    output logic                               cfgClockLineOe,
    input  wire logic                          cfgDataLineIn,
    output logic                               cfgDataLineOut,
    output logic                               cfgDataLineOe,
    output spa_autoload_pkg::spa_imem_wr_t     imemWrite,
    output logic [7:0]                         cfgByte0,
    output logic [7:0]                         cfgByte1,
    output spa_autoload_pkg::spa_audio_en_t    audioEnable,
    output logic                               loadDone
);

    ////////////////////////////////////////////////////////////////////////////
    // State record
    // One record holds all sequencer state (the pin synchronisers keep their own flops); one register stage updates it
    typedef struct packed {
        spa_autoload_pkg::spa_state_t    st;
        logic [1:0]                      strapCnt;
        logic [10:0]                     periodCnt;
        logic [5:0]                      phaseCnt;
        logic [5:0]                      bitCnt;
        logic [9:0]                      wordAddr;
        logic                            cfgPhase;
        logic [39:0]                     shift;
        logic                            clkOut;
        logic                            clkOe;
        logic                            dataOut;
        logic                            dataOe;
        spa_autoload_pkg::spa_imem_wr_t  imem;
        logic [7:0]                      cfg0;
        logic [7:0]                      cfg1;
        spa_autoload_pkg::spa_audio_en_t audio;
        logic                            done;
    } spa_loader_t;

    // Everything clears, so a reset restarts the load from the top
    localparam spa_loader_t RESET_STATE = '{
        st:        spa_autoload_pkg::ST_STRAP,
        strapCnt:  2'h0,
        periodCnt: 11'h000,
        phaseCnt:  6'h00,
        bitCnt:    6'h00,
        wordAddr:  10'h000,
        cfgPhase:  1'b0,
        shift:     40'h00_0000_0000,
        clkOut:    1'b0,
        clkOe:     1'b0,
        dataOut:   1'b0,
        dataOe:    1'b0,
        imem:      '0,
        cfg0:      8'h00,
        cfg1:      8'h00,
        audio:     '0,
        done:      1'b0
    };

    // Current record and its next value
    spa_loader_t r;
    spa_loader_t next_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Straps and data idle high through pull-ups; sample clock low
    logic autoloadSync;
    logic hostSelSync;
    logic sampleRise;
    logic dataSync;

    // Autoload select strap
    spa_sync_rise #(.RST_LEVEL(1'b1)) u_sync_auto (
        .clk   (clk),
        .rst_n (rst_n),
        .pinIn (autoloadSelectN),
        .level (autoloadSync),
        .rise  ()
    );

    // Serial host select strap
    spa_sync_rise #(.RST_LEVEL(1'b1)) u_sync_host (
        .clk   (clk),
        .rst_n (rst_n),
        .pinIn (serialHostSelectN),
        .level (hostSelSync),
        .rise  ()
    );

    // Sample-rate clock; only its rising edges matter
    spa_sync_rise #(.RST_LEVEL(1'b0)) u_sync_wclk (
        .clk   (clk),
        .rst_n (rst_n),
        .pinIn (sampleRateClock),
        .level (),
        .rise  (sampleRise)
    );

    // Serial data from the PROM
    spa_sync_rise #(.RST_LEVEL(1'b1)) u_sync_data (
        .clk   (clk),
        .rst_n (rst_n),
        .pinIn (cfgDataLineIn),
        .level (dataSync),
        .rise  ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    logic [5:0] groupLen;

    always_comb begin
        // Hold everything, drop the strobe, pick the group length
        next_r          = r;
        next_r.imem.we  = 1'b0;                      // Write strobe is one cycle
        groupLen        = r.cfgPhase ? spa_autoload_pkg::CFG_BITS
                                     : spa_autoload_pkg::WORD_BITS;
        unique case (r.st)
            spa_autoload_pkg::ST_STRAP: begin
                // Let the straps pass the synchronisers before deciding
                if (r.strapCnt == spa_autoload_pkg::STRAP_SETTLE) begin
                    if (!autoloadSync && hostSelSync) begin  // [RL1]
                        next_r.st        = spa_autoload_pkg::ST_PLL_WAIT;
                        next_r.clkOe     = 1'b1;          // [RL2]
                        next_r.periodCnt = 11'h000;
                    end else begin
                        next_r.st = spa_autoload_pkg::ST_OFF;
                    end
                end else begin
                    next_r.strapCnt = r.strapCnt + 2'h1;
                end
            end

            spa_autoload_pkg::ST_PLL_WAIT: begin
                // Count sample periods before the first pulse
                if (sampleRise) begin
                    if (r.periodCnt == spa_autoload_pkg::PLL_WAIT_PERIODS - 11'h001) begin
                        next_r.st       = spa_autoload_pkg::ST_CLK_HIGH;  // [RL8]
                        next_r.clkOut   = 1'b1;
                        next_r.phaseCnt = 6'h00;
                        next_r.bitCnt   = 6'h00;
                    end else begin
                        next_r.periodCnt = r.periodCnt + 11'h001;
                    end
                end
            end

            spa_autoload_pkg::ST_WAIT_EDGE: begin
                // Each group opens on a sample-clock rise
                if (sampleRise) begin
                    next_r.st       = spa_autoload_pkg::ST_CLK_HIGH;  // [RL9]
                    next_r.clkOut   = 1'b1;
                    next_r.phaseCnt = 6'h00;
                    next_r.bitCnt   = 6'h00;
                end
            end

            spa_autoload_pkg::ST_CLK_HIGH: begin
                next_r.phaseCnt = r.phaseCnt + 6'h01;
                // Bit was present at the rising edge; take it once synchronised
                if (r.phaseCnt == spa_autoload_pkg::SAMPLE_AT) begin
                    next_r.shift = {r.shift[38:0], dataSync};  // [RL10] [RL4]
                end
                // End of the high phase
                if (r.phaseCnt == spa_autoload_pkg::CFG_HALF_CYC - 6'h01) begin
                    next_r.st       = spa_autoload_pkg::ST_CLK_LOW;   // [RL9]
                    next_r.clkOut   = 1'b0;
                    next_r.phaseCnt = 6'h00;
                end
            end

            spa_autoload_pkg::ST_CLK_LOW: begin
                // Low phase; its end closes one bit
                next_r.phaseCnt = r.phaseCnt + 6'h01;
                if (r.phaseCnt == spa_autoload_pkg::CFG_HALF_CYC - 6'h01) begin
                    next_r.phaseCnt = 6'h00;
                    next_r.bitCnt   = r.bitCnt + 6'h01;
                    // First config byte is complete after its eighth bit
                    if (r.cfgPhase && r.bitCnt == spa_autoload_pkg::CFG_BYTE_BITS - 6'h01) begin
                        next_r.cfg0 = r.shift[7:0];        // [RL5] [RL14]
                    end
                    // Last bit of the group
                    if (r.bitCnt == groupLen - 6'h01) begin
                        if (r.cfgPhase) begin
                            // Nothing past the second byte is clocked
                            next_r.cfg1      = r.shift[7:0];   // [RL5] [RL14] [RL6]
                            next_r.st        = spa_autoload_pkg::ST_MUTED;
                            next_r.periodCnt = 11'h000;
                        end else begin
                            next_r.imem.we   = 1'b1;          // [RL14] [RL11]
                            next_r.imem.addr = r.wordAddr;
                            next_r.imem.data = r.shift;
                            next_r.wordAddr  = r.wordAddr + 10'h001;
                            next_r.st        = spa_autoload_pkg::ST_WAIT_EDGE;
                            if (r.wordAddr == spa_autoload_pkg::LAST_WORD_ADDR) begin
                                next_r.cfgPhase = 1'b1;       // [RL11]
                            end
                        end
                    end else begin
                        next_r.st     = spa_autoload_pkg::ST_CLK_HIGH;
                        next_r.clkOut = 1'b1;
                    end
                end
            end

            spa_autoload_pkg::ST_MUTED: begin
                // Program runs with serial I/O held muted
                if (sampleRise) begin
                    if (r.periodCnt == spa_autoload_pkg::MUTE_PERIODS - 11'h001) begin
                        next_r.st = spa_autoload_pkg::ST_RUN;  // [RL12]
                        next_r.audio.outEnable =
                            r.cfg0[spa_autoload_pkg::CFG0_OUT_EN_MSB:
                                   spa_autoload_pkg::CFG0_OUT_EN_LSB];  // [RL13]
                        next_r.audio.inEnable =
                            r.cfg0[spa_autoload_pkg::CFG0_IN_EN_BIT];  // [RL13]
                        next_r.done = 1'b1;
                    end else begin
                        next_r.periodCnt = r.periodCnt + 11'h001;
                    end
                end
            end

            spa_autoload_pkg::ST_RUN: begin
                // Load finished; stay here until the next reset
                next_r.st = spa_autoload_pkg::ST_RUN;
            end

            spa_autoload_pkg::ST_OFF: begin
                // Not in autoload mode; the link is never driven
                next_r.st = spa_autoload_pkg::ST_OFF;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset aborts any load in progress
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= RESET_STATE;                            // [RL15]
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state record
    // Link pins; the data pin is never driven
    assign cfgClockLineOut = r.clkOut;
    assign cfgClockLineOe  = r.clkOe;
    assign cfgDataLineOut  = r.dataOut;
    assign cfgDataLineOe   = r.dataOe;

    // Loaded image, config bytes and status
    assign imemWrite       = r.imem;
    assign cfgByte0        = r.cfg0;
    assign cfgByte1        = r.cfg1;
    assign audioEnable     = r.audio;
    assign loadDone        = r.done;

endmodule // spa_autoloader

//--- spa_autoload_checker.sv
// Port-level checks for the serial PROM autoloader.
// Assumes one clk domain with async active-low rst_n; bound to spa_autoloader.
`timescale 1ns/1ps
module spa_autoload_checker (
    input wire logic                            clk,
    input wire logic                            rst_n,
    input wire logic                            autoloadSelectN,
    input wire logic                            serialHostSelectN,
    input wire logic                            sampleRateClock,
    input wire logic                            cfgClockLineIn,
    input wire logic                            cfgClockLineOut,
    input wire logic                            cfgClockLineOe,
    input wire logic                            cfgDataLineIn,
    input wire logic                            cfgDataLineOut,
    input wire logic                            cfgDataLineOe,
    input wire spa_autoload_pkg::spa_imem_wr_t  imemWrite,
    input wire logic [7:0]                      cfgByte0,
    input wire logic [7:0]                      cfgByte1,
    input wire spa_autoload_pkg::spa_audio_en_t audioEnable,
    input wire logic                            loadDone
);
    ////////////////////////////////////////////////////////////////////////////
    // Helper counters: phase widths, pulses, word address, raw sample rises
    logic [5:0]  hiCnt;
    logic [6:0]  loCnt;
    logic [5:0]  pulCnt;
    logic [9:0]  expAddr;
    logic [11:0] smpCnt;
    logic        smpPrev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hiCnt <= 6'h00;
            loCnt <= 7'h00;
            pulCnt <= 6'h00;
            expAddr <= 10'h000;
            smpCnt <= 12'h000;
            smpPrev <= 1'b0;
        end else begin
            hiCnt <= cfgClockLineOut ? hiCnt + 6'h01 : 6'h00;
            loCnt <= cfgClockLineOut ? 7'h00 : loCnt + {6'h00, ~&loCnt};
            pulCnt <= imemWrite.we ? 6'h00 : pulCnt + {5'h00, cfgClockLineOut && hiCnt == 6'h00};
            expAddr <= expAddr + {9'h000, imemWrite.we};
            smpPrev <= sampleRateClock;
            smpCnt <= smpCnt + {11'h000, sampleRateClock & ~smpPrev & ~&smpCnt};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin, pulse, load and unmute relations
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_high_run;
        cfgClockLineOut [*8];
    endsequence
    a_high_start: assert property ($rose(cfgClockLineOut) |-> s_high_run)
        else $error("clock high phase cut short");
    a_high_len: assert property ($fell(cfgClockLineOut) |-> hiCnt == 6'h20)
        else $error("clock high phase length wrong");
    a_low_len: assert property (cfgClockLineOut && hiCnt == 6'h00 |-> loCnt >= 7'h20)
        else $error("clock low phase too short");
    a_pll_wait: assert property (
        cfgClockLineOut && expAddr == 10'h000 && pulCnt == 6'h00 |-> smpCnt >= 12'h400)
        else $error("clock pulse before sample wait ended");
    a_word_bits: assert property (imemWrite.we |-> pulCnt == 6'h28)
        else $error("word written after wrong pulse count");
    a_word_addr: assert property (imemWrite.we |-> imemWrite.addr == expAddr)
        else $error("word address out of order");
    a_we_pulse: assert property (imemWrite.we |=> !imemWrite.we)
        else $error("write strobe longer than one cycle");
    a_cfg0_load: assert property ($changed(cfgByte0) |-> pulCnt == 6'h08)
        else $error("config byte 0 loaded at wrong bit");
    a_cfg1_load: assert property ($changed(cfgByte1) |-> pulCnt == 6'h10)
        else $error("config byte 1 loaded at wrong bit");
    a_data_input: assert property (!cfgDataLineOe)
        else $error("data pin driven");
    a_clock_drive: assert property (cfgClockLineOut |-> cfgClockLineOe)
        else $error("clock high while pin not driven");
    a_host_quiet: assert property (autoloadSelectN || !serialHostSelectN |-> !cfgClockLineOe)
        else $error("clock pin driven outside autoload mode");
    a_muted_run: assert property (audioEnable != 5'h00 |-> loadDone)
        else $error("audio enabled before muted run ended");
    a_enable_map: assert property (loadDone |-> audioEnable == {cfgByte0[6:3], cfgByte0[2]})
        else $error("audio enables differ from config byte 0");
endmodule // spa_autoload_checker

bind spa_autoloader spa_autoload_checker i_spa_autoload_checker (
    .clk(clk), .rst_n(rst_n), .autoloadSelectN(autoloadSelectN),
    .serialHostSelectN(serialHostSelectN), .sampleRateClock(sampleRateClock),
    .cfgClockLineIn(cfgClockLineIn), .cfgClockLineOut(cfgClockLineOut),
    .cfgClockLineOe(cfgClockLineOe), .cfgDataLineIn(cfgDataLineIn),
    .cfgDataLineOut(cfgDataLineOut), .cfgDataLineOe(cfgDataLineOe), .imemWrite(imemWrite),
    .cfgByte0(cfgByte0), .cfgByte1(cfgByte1), .audioEnable(audioEnable), .loadDone(loadDone)
);

//--- spa_prom_model.sv
// Behavioural serial configuration PROM on the link pins.
// Assumes it restarts with the device reset and shifts on clock falls.
`timescale 1ns/1ps
module spa_prom_model (
    input wire logic rst_n,
    input wire logic cfgClock,
    output logic     dataOut
);
    logic [15:0] bitIdx;
    logic [39:0] word;
    localparam logic [15:0] CFG_IMAGE = 16'h5ca3; // Both config bytes, byte 0 first
    // Image word stored for each instruction address
    function automatic logic [39:0] imageWord(input logic [9:0] a);
        return {a, 6'h2b, ~a, 4'h9, a};
    endfunction
    // Step to the next bit after each falling clock edge
    always @(negedge cfgClock or negedge rst_n) begin
        if (!rst_n) begin
            bitIdx <= 16'h0000;
        end else begin
            bitIdx <= bitIdx + 16'h0001;
        end
    end
    // Words MSB first, then both config bytes, then filler the device must skip
    always_comb begin
        word = imageWord(10'(bitIdx / 16'h0028));
        if (bitIdx < 16'ha000) begin
            dataOut = word[16'h0027 - (bitIdx % 16'h0028)];
        end else if (bitIdx < 16'ha010) begin
            dataOut = CFG_IMAGE[4'hf - 4'(bitIdx - 16'ha000)];
        end else begin
            dataOut = bitIdx[0];
        end
    end
endmodule // spa_prom_model

//--- spa_autoloader_tb.sv
// Self-checking bench: straps, sample clock and a PROM model on the link.
// Assumes spa_autoload_pkg, spa_autoloader, its checker and spa_prom_model.
`timescale 1ns/1ps
module spa_autoloader_tb;
    logic                            clk = 1'b0;
    logic                            rst_n = 1'b0;
    logic                            autoloadSelectN = 1'b0;
    logic                            serialHostSelectN = 1'b1;
    logic                            sampleRateClock = 1'b0;
    logic                            cfgClockLineOut, cfgClockLineOe, promData;
    logic                            cfgDataLineOut, cfgDataLineOe, loadDone;
    logic [7:0]                      cfgByte0, cfgByte1;
    logic [11:0]                     riseCnt;
    spa_autoload_pkg::spa_imem_wr_t  imemWrite;
    spa_autoload_pkg::spa_audio_en_t audioEnable;
    int                              err_total = 0;
    int                              compares = 0;
    // Clock pin has a pull-down, data pin comes from the PROM
    wire logic cfgClockPin = cfgClockLineOe ? cfgClockLineOut : 1'b0;
    wire logic cfgDataPin = cfgDataLineOe ? cfgDataLineOut : promData;

    ////////////////////////////////////////////////////////////////////////////
    // Clocks and a raw count of sample-clock rises since reset
    always #2.5 clk = ~clk;
    initial begin
        #37;
        forever #80 sampleRateClock = ~sampleRateClock;
    end
    always @(posedge sampleRateClock or negedge rst_n) begin
        if (!rst_n) riseCnt <= 12'h000;
        else riseCnt <= riseCnt + 12'h001;
    end

    spa_autoloader i_spa_autoloader (
        .clk(clk), .rst_n(rst_n), .autoloadSelectN(autoloadSelectN),
        .serialHostSelectN(serialHostSelectN), .sampleRateClock(sampleRateClock),
        .cfgClockLineIn(cfgClockPin), .cfgClockLineOut(cfgClockLineOut),
        .cfgClockLineOe(cfgClockLineOe), .cfgDataLineIn(cfgDataPin),
        .cfgDataLineOut(cfgDataLineOut), .cfgDataLineOe(cfgDataLineOe), .imemWrite(imemWrite),
        .cfgByte0(cfgByte0), .cfgByte1(cfgByte1), .audioEnable(audioEnable), .loadDone(loadDone)
    );
    spa_prom_model i_spa_prom_model (.rst_n(rst_n), .cfgClock(cfgClockPin), .dataOut(promData));

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and reset helpers
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic doReset(input logic sel, input logic host);
        @(negedge clk);
        rst_n = 1'b0;
        autoloadSelectN = sel;
        serialHostSelectN = host;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    // Other strap settings never drive the link or load anything
    task automatic scenHostQuiet();
        logic [1:0] straps [3] = '{2'b11, 2'b10, 2'b00};
        logic busy;
        for (int k = 0; k < 3; k++) begin
            doReset(straps[k][1], straps[k][0]);
            busy = 1'b0;
            repeat (600) begin
                @(posedge clk);
                #1;
                busy |= cfgClockLineOe | cfgClockLineOut | imemWrite.we | loadDone;
            end
            check(64'(busy), 64'h0);
        end
    endtask
    // Count pulses of one group and judge the word it writes
    task automatic catchWord(input logic [9:0] addr, input logic first);
        int n;
        int pulses;
        logic [11:0] rc;
        logic prev;
        pulses = 0;
        rc = 12'h000;
        @(posedge clk);
        #1;
        prev = cfgClockLineOut;
        for (n = 0; n < 40000 && imemWrite.we !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (cfgClockLineOut === 1'b1 && prev !== 1'b1) begin
                if (pulses == 0) rc = riseCnt;
                pulses++;
            end
            prev = cfgClockLineOut;
        end
        check(64'(n < 40000), 64'h1);
        if (first) check(64'(rc >= 12'h400 && rc <= 12'h402), 64'h1);
        check(64'(pulses), 64'h28);
        check(64'(imemWrite.addr), 64'(addr));
        check(64'(imemWrite.data), 64'(i_spa_prom_model.imageWord(addr)));
        check(64'({cfgClockLineOe, cfgDataLineOe, audioEnable, loadDone}), 64'h80);
        check(64'({cfgByte1, cfgByte0}), 64'h0);
    endtask
    // Autoload straps, then the first three words in order
    task automatic scenLoadWords();
        doReset(1'b0, 1'b1);
        catchWord(10'h000, 1'b1);
        catchWord(10'h001, 1'b0);
        catchWord(10'h002, 1'b0);
    endtask
    // Reset in mid-group, then the load starts over from the wait
    task automatic scenAbort();
        repeat (100) @(negedge clk);
        doReset(1'b0, 1'b1);
        catchWord(10'h000, 1'b1);
    endtask

    initial begin
        scenHostQuiet();
        scenLoadWords();
        scenAbort();
        summarize();
    end
    // Watchdog sized only about a sixth above the expected run
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule // spa_autoloader_tb
